// ===== src/anr_top.sv
// Negotiation arbitration: parallel detect, priority resolution and next page exchange.
// Function
// - A fixed 100Base-TX partner seen by parallel detect brings up that attachment if supported, else link is refused.
// - A fixed 100Base-T4 partner seen before any pulse burst brings up that attachment if supported, else link stays down.
// - After the base exchange the highest priority common technology of the first five ability bits is chosen, or link is refused.
// - Full duplex is chosen whenever both ends offer the full duplex form of the resolved technology.
// - A link failure from the resolved technology while link is up restarts negotiation.
// - When both ends offer next pages and share a technology, each sends at least one next page after the base acknowledge phase.
// - Next pages go out through the same burst generator and timing as the base page.
// - Next pages pass the same consistency check as base pages before they are acknowledged.
// - A received next page inconsistent with the matched one stops next page transmission at once.
// - After its last real page the block sends null message pages, code one, until the partner is done.
// - With no data the block sends nulls with the more flag set and, after a partner page with its more flag clear, one final null with it clear.
// - User pages carry the more flag given with them, and every null after the last user page carries it clear.
// - The toggle flag alternates between pages and a page with the wrong toggle is waited past.
`include "anr_defs.svh"

module anr_top (
  input  wire logic             i_clock,         // System clock, 125 MHz.
  input  wire logic             i_rstn,          // Asynchronous reset, active low.
  input  wire logic             i_rx_clk,        // Recovered clock pulse of received bursts.
  input  wire logic             i_rx_data,       // Recovered data bit of received bursts.
  input  wire logic             i_rx_frame,      // High for the length of a received burst.
  input  wire logic             i_pd_tx,         // Idle of a fixed 100Base-TX partner detected.
  input  wire logic             i_pd_t4,         // Signalling of a fixed 100Base-T4 partner detected.
  input  wire logic [4:0]       i_local_ability, // Local technology ability bits.
  input  wire logic             i_local_np,      // Local next page ability.
  input  wire logic             i_base_toggle,   // Toggle bit of the local base word.
  input  wire logic             i_ack_complete,  // Base complete acknowledge finished, pulse.
  input  wire logic             i_link_fail,     // Resolved technology reports link failure.
  input  wire logic             i_renegotiate,   // Leave a refused or halted state, pulse.
  input  wire logic             i_np_avail,      // A user next page is waiting.
  input  wire logic             i_np_more,       // More user pages follow the waiting one.
  input  wire logic             i_np_mp,         // Waiting page is a message page.
  input  wire logic [10:0]      i_np_code,       // Code field of the waiting page.
  output logic                  o_np_take,       // Waiting user page consumed, pulse.
  output anr_pkg::anr_page_t    o_tx_page,       // Next page for the burst generator.
  output logic                  o_tx_valid,      // Send o_tx_page as next page bursts.
  output anr_pkg::anr_tech_t    o_hcd,           // Resolved highest common technology.
  output logic                  o_full_duplex,   // Resolved operation is full duplex.
  output logic                  o_link_up,       // Link is up on o_hcd.
  output logic                  o_pma_tx_en,     // Enable the 100Base-TX medium attachment.
  output logic                  o_pma_t4_en,     // Enable the 100Base-T4 medium attachment.
  output logic                  o_refused,       // Link refused.
  output logic                  o_restart        // Restart negotiation, pulse.
);

  anr_pkg::anr_state_t st;
  anr_pkg::anr_state_t next_st;
  anr_pkg::anr_page_t  word;
  anr_pkg::anr_page_t  cand;
  anr_pkg::anr_page_t  partner_base;
  anr_pkg::anr_page_t  next_page;
  anr_pkg::anr_tech_t  best;
  logic [2:0]          rx_s;
  logic                clk_q;
  logic                frame_q;
  logic [15:0]         shift;
  logic [4:0]          bits;
  logic                word_valid;
  logic [1:0]          cnt;
  logic                taken;
  logic                flp_seen;
  logic                exp_tog;
  logic                our_last;

  // Pins of the wire side pass the three stage synchroniser.
  anr_sync #(.W(`ANR_SYNC_STAGES)) u_sync (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async ({i_rx_frame, i_rx_data, i_rx_clk}),
    .o_sync  (rx_s)
  );

  wire clk_rise   = rx_s[0] & ~clk_q;
  wire frame_fall = ~rx_s[2] & frame_q;

  // Deserialiser: D0 arrives first, a word is complete when the burst ends.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_q      <= 1'b0;
      frame_q    <= 1'b0;
      shift      <= 16'h0000;
      bits       <= 5'h00;
      word_valid <= 1'b0;
      word       <= '0;
    end else begin
      clk_q      <= rx_s[0];
      frame_q    <= rx_s[2];
      word_valid <= frame_fall && bits == `ANR_WORD_BITS;
      if (frame_fall) begin
        word <= shift;
        bits <= 5'h00;
      end else if (clk_rise && rx_s[2] && bits != `ANR_WORD_BITS) begin
        shift <= {rx_s[1], shift[15:1]};
        bits  <= bits + 5'h01;
      end
    end
  end

  // Consistency check on every received word, base or next page.
  wire same      = word == cand;
  wire accept    = word_valid && same && word.ack && cnt >= 2'h2 && !taken;
  wire [14:0] strip_w = {word.more, word[13:0]};
  wire [14:0] strip_c = {cand.more, cand[13:0]};
  wire incons    = st == anr_pkg::ST_NEXT_PAGE && word_valid && cnt == `ANR_MATCH_COUNT
                   && word.ack && word.toggle == cand.toggle && strip_w != strip_c;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cand  <= '0;
      cnt   <= 2'h0;
      taken <= 1'b0;
    end else if (word_valid) begin
      cand  <= word;
      cnt   <= !same ? 2'h1 : (cnt == `ANR_MATCH_COUNT ? cnt : cnt + 2'h1);
      taken <= same ? (taken | accept) : 1'b0;
    end
  end

  // Priority resolution over the first five ability bits, 100Base-TX full duplex first.
  wire [4:0] common = i_local_ability & partner_base[`ANR_TECH_LSB +: `ANR_TECH_BITS];
  assign best = common[3] ? anr_pkg::TECH_TXFD :
                common[4] ? anr_pkg::TECH_T4 :
                common[2] ? anr_pkg::TECH_TX :
                common[1] ? anr_pkg::TECH_10FD :
                common[0] ? anr_pkg::TECH_10 : anr_pkg::TECH_NONE;
  wire tx_ok = i_local_ability[2] | i_local_ability[3];
  wire t4_ok = i_local_ability[4];

  // Page to send next; partner_done is the partner's state after this accept.
  wire partner_done = accept && !word.more;
  wire use_user     = i_np_avail && !our_last;
  always_comb begin
    next_page        = '0;
    next_page.ack    = 1'b0;
    next_page.msg    = use_user ? i_np_mp : 1'b1;
    next_page.code   = use_user ? i_np_code : `ANR_NULL_CODE;
    next_page.more   = our_last ? 1'b0 : (use_user ? i_np_more : ~partner_done);
    next_page.toggle = st == anr_pkg::ST_NEXT_PAGE ? ~o_tx_page.toggle : ~i_base_toggle;
  end

  wire both_np   = i_local_np && partner_base.more;
  wire good_tog  = accept && word.toggle == exp_tog;
  wire both_done = good_tog && !o_tx_page.more && !word.more;

  // State decision.
  always_comb begin
    next_st = st;
    case (st)
      anr_pkg::ST_DETECT: begin
        if (!flp_seen && i_pd_tx) begin
          next_st = tx_ok ? anr_pkg::ST_LINK : anr_pkg::ST_REFUSE;
        end else if (!flp_seen && i_pd_t4) begin
          next_st = t4_ok ? anr_pkg::ST_LINK : anr_pkg::ST_REFUSE;
        end else if (i_ack_complete) begin
          next_st = best == anr_pkg::TECH_NONE ? anr_pkg::ST_REFUSE :
                    both_np ? anr_pkg::ST_NEXT_PAGE : anr_pkg::ST_LINK;
        end
      end
      anr_pkg::ST_NEXT_PAGE: begin
        if (incons) begin
          next_st = anr_pkg::ST_HALT;
        end else if (both_done) begin
          next_st = anr_pkg::ST_LINK;
        end
      end
      anr_pkg::ST_LINK: begin
        if (i_link_fail) begin
          next_st = anr_pkg::ST_DETECT;
        end
      end
      anr_pkg::ST_REFUSE,
      anr_pkg::ST_HALT: begin
        if (i_renegotiate) begin
          next_st = anr_pkg::ST_DETECT;
        end
      end
      default: next_st = anr_pkg::ST_DETECT;
    endcase
  end

  wire enter_np = st == anr_pkg::ST_DETECT && next_st == anr_pkg::ST_NEXT_PAGE;
  wire advance  = st == anr_pkg::ST_NEXT_PAGE && good_tog && next_st == anr_pkg::ST_NEXT_PAGE;
  wire restart  = next_st == anr_pkg::ST_DETECT && st != anr_pkg::ST_DETECT;

  // State, resolution and handshake registers.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st        <= anr_pkg::ST_DETECT;
      o_hcd     <= anr_pkg::TECH_NONE;
      o_restart <= 1'b0;
      flp_seen  <= 1'b0;
      partner_base <= '0;
    end else begin
      st        <= next_st;
      o_restart <= restart;
      if (restart) begin
        o_hcd    <= anr_pkg::TECH_NONE;
        flp_seen <= 1'b0;
      end else if (st == anr_pkg::ST_DETECT) begin
        flp_seen <= flp_seen | word_valid;
        if (accept) begin
          partner_base <= word;
        end
        if (!flp_seen && i_pd_tx) begin
          o_hcd <= tx_ok ? anr_pkg::TECH_TX : anr_pkg::TECH_NONE;
        end else if (!flp_seen && i_pd_t4) begin
          o_hcd <= t4_ok ? anr_pkg::TECH_T4 : anr_pkg::TECH_NONE;
        end else if (i_ack_complete) begin
          o_hcd <= best;
        end
      end
    end
  end

  // Next page transmit side; pages go to the base page burst generator.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_page  <= '0;
      o_tx_valid <= 1'b0;
      o_np_take  <= 1'b0;
      exp_tog    <= 1'b0;
      our_last   <= 1'b0;
    end else begin
      o_np_take <= (enter_np || advance) && use_user;
      if (enter_np || advance) begin
        o_tx_page  <= next_page;
        o_tx_valid <= 1'b1;
        our_last   <= ~next_page.more;
        exp_tog    <= enter_np ? ~partner_base.toggle : ~exp_tog;
      end else if (next_st != anr_pkg::ST_NEXT_PAGE) begin
        o_tx_valid <= 1'b0;
        our_last   <= 1'b0;
      end
    end
  end

  // Status decode from registered state.
  assign o_link_up     = st == anr_pkg::ST_LINK;
  assign o_refused     = st == anr_pkg::ST_REFUSE;
  assign o_full_duplex = o_hcd == anr_pkg::TECH_TXFD || o_hcd == anr_pkg::TECH_10FD;
  assign o_pma_tx_en   = o_link_up && (o_hcd == anr_pkg::TECH_TX || o_hcd == anr_pkg::TECH_TXFD);
  assign o_pma_t4_en   = o_link_up && o_hcd == anr_pkg::TECH_T4;

  // Checks on the arbitration behaviour.
  a_pd_tx_link: assert property (@(posedge i_clock) disable iff (!i_rstn)
    st == anr_pkg::ST_DETECT && !flp_seen && i_pd_tx |=> (tx_ok ? o_pma_tx_en : o_refused))
    else $error("TX parallel detect not resolved");
  a_pd_t4_link: assert property (@(posedge i_clock) disable iff (!i_rstn)
    st == anr_pkg::ST_DETECT && !flp_seen && !i_pd_tx && i_pd_t4 |=> (t4_ok ? o_pma_t4_en : o_refused))
    else $error("T4 parallel detect not resolved");
  a_no_common_refuse: assert property (@(posedge i_clock) disable iff (!i_rstn)
    st == anr_pkg::ST_DETECT && (flp_seen || !(i_pd_tx || i_pd_t4)) && i_ack_complete && common == 5'h00
    |=> o_refused && o_hcd == anr_pkg::TECH_NONE)
    else $error("Link not refused without common technology");
  a_full_duplex_pick: assert property (@(posedge i_clock) disable iff (!i_rstn)
    st == anr_pkg::ST_DETECT && flp_seen && i_ack_complete && common[3] |=> o_full_duplex)
    else $error("Full duplex not selected");
  a_fail_restart: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_link_up && i_link_fail |=> o_restart && !o_link_up ##1 !o_restart)
    else $error("Link failure did not restart negotiation");
  a_first_np_sent: assert property (@(posedge i_clock) disable iff (!i_rstn)
    enter_np |=> o_tx_valid && o_tx_page.toggle == !i_base_toggle)
    else $error("First next page not sent");
  a_incons_stop: assert property (@(posedge i_clock) disable iff (!i_rstn)
    incons |=> !o_tx_valid && st == anr_pkg::ST_HALT)
    else $error("Transmission not stopped on inconsistent page");
  a_toggle_alt: assert property (@(posedge i_clock) disable iff (!i_rstn)
    advance |=> o_tx_page.toggle != $past(o_tx_page.toggle))
    else $error("Toggle did not alternate");
  a_last_null_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
    advance && !use_user && partner_done |=> !o_tx_page.more && o_tx_page.code == `ANR_NULL_CODE)
    else $error("Final null page keeps more flag");
  a_both_done_link: assert property (@(posedge i_clock) disable iff (!i_rstn)
    st == anr_pkg::ST_NEXT_PAGE && both_done && !incons |=> o_link_up && !o_tx_valid)
    else $error("Exchange did not end in link");

endmodule : anr_top

// ===== src/anr_defs.svh
// Constants for the negotiation arbitration block.
`ifndef ANR_DEFS_SVH
`define ANR_DEFS_SVH

// Bits in one received or transmitted code word.
`define ANR_WORD_BITS   5'h10
// Position of the lowest technology ability bit in a base word.
`define ANR_TECH_LSB    5
// Number of technology ability bits taken into resolution.
`define ANR_TECH_BITS   5
// Identical words needed before a word is accepted.
`define ANR_MATCH_COUNT 2'h3
// Message code of a null message page.
`define ANR_NULL_CODE   11'h001
// Width of the pin synchroniser, one bit per synchronised pin.
`define ANR_SYNC_STAGES 3

`endif

// ===== src/anr_pkg.sv
// Types shared by the negotiation arbitration block.
package anr_pkg;

  // Resolved technology, lowest priority first after none.
  typedef enum logic [2:0] {
    TECH_NONE,
    TECH_10,
    TECH_10FD,
    TECH_TX,
    TECH_T4,
    TECH_TXFD
  } anr_tech_t;

  // Arbitration states.
  typedef enum logic [2:0] {
    ST_DETECT,
    ST_NEXT_PAGE,
    ST_LINK,
    ST_REFUSE,
    ST_HALT
  } anr_state_t;

  // One code word as carried on the wire, bit 15 first in the struct.
  typedef struct packed {
    logic        more;
    logic        ack;
    logic        msg;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } anr_page_t;

endpackage : anr_pkg

// ===== src/anr_sync.sv
// Three stage pin synchroniser that changes once the last two stages agree.
module anr_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clock,  // System clock.
  input  wire logic         i_rstn,   // Asynchronous reset, active low.
  input  wire logic [W-1:0] i_async,  // Inputs from outside the clock domain.
  output logic      [W-1:0] o_sync    // Filtered synchronous copy.
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);

  // The first stage feeds only the second; the output follows only agreed bits.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      o_sync <= (agree & stage3) | (~agree & o_sync);
    end
  end

endmodule : anr_sync

// ===== tb/anr_partner.sv
// Link partner model that sends code words as clocked pulse bursts.
module anr_partner (
  input  wire logic i_clock,   // Bench clock, used only as a time base.
  output logic      o_rx_clk,  // Burst clock pulses.
  output logic      o_rx_data, // Burst data bits.
  output logic      o_rx_frame // High for the length of one burst.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines start idle so the block sees no burst before the first word.
  initial begin
    o_rx_clk = 1'b0;
    o_rx_data = 1'b0;
    o_rx_frame = 1'b0;
  end

  // Sends a word n times, bit 0 first, with a 160 ns link clock that stands still between bursts.
  // Data flips after each burst so a stale bit can never pass for a sampled one.
  task automatic send_word(input logic [15:0] w, input int n);
    repeat (n) begin
      @(negedge i_clock);
      o_rx_frame = 1'b1;
      for (int i = 0; i < 16; i++) begin
        o_rx_data = w[i];
        repeat (10) @(negedge i_clock);
        o_rx_clk = 1'b1;
        repeat (10) @(negedge i_clock);
        o_rx_clk = 1'b0;
      end
      repeat (10) @(negedge i_clock);
      o_rx_frame = 1'b0;
      o_rx_data = ~o_rx_data;
      repeat (40) @(negedge i_clock);
    end
  endtask : send_word
endmodule : anr_partner

// ===== tb/anr_top_tb.sv
// Self-checking bench for the negotiation arbitration block.
`include "anr_defs.svh"

module anr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               i_clock, i_rstn, rx_clk, rx_data, rx_frame, pd_tx, pd_t4, local_np, base_toggle;
  logic               ack_complete, link_fail, renegotiate, np_avail, np_more, np_mp, np_take, tx_valid;
  logic               full_duplex, link_up, pma_tx_en, pma_t4_en, refused, restart;
  logic [4:0]         ability, p, c;
  logic [10:0]        np_code;
  anr_pkg::anr_page_t tx_page;
  anr_pkg::anr_tech_t highest_common_technology, eh;
  int                 failures, comparisons;
  wire  [2:0]         flags = {restart, ~tx_valid, link_up};

  anr_top DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_rx_clk(rx_clk), .i_rx_data(rx_data), .i_rx_frame(rx_frame),
    .i_pd_tx(pd_tx), .i_pd_t4(pd_t4), .i_local_ability(ability), .i_local_np(local_np),
    .i_base_toggle(base_toggle), .i_ack_complete(ack_complete), .i_link_fail(link_fail),
    .i_renegotiate(renegotiate), .i_np_avail(np_avail), .i_np_more(np_more), .i_np_mp(np_mp),
    .i_np_code(np_code), .o_np_take(np_take), .o_tx_page(tx_page), .o_tx_valid(tx_valid), .o_hcd(highest_common_technology),
    .o_full_duplex(full_duplex), .o_link_up(link_up), .o_pma_tx_en(pma_tx_en), .o_pma_t4_en(pma_t4_en),
    .o_refused(refused), .o_restart(restart)
  );
  anr_partner u_partner (.i_clock(i_clock), .o_rx_clk(rx_clk), .o_rx_data(rx_data), .o_rx_frame(rx_frame));

  // Free running 125 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // The user page is withdrawn once the block reports that it took it.
  always @(negedge i_clock) begin
    if (np_take === 1'b1) np_avail <= 1'b0;
  end

  // Reports the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Shared comparison behind the typed compare tasks.
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    comparisons++;
    if (a !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask : cmp
  task automatic check_bit(input logic a, input logic e); cmp({15'h0000, a}, {15'h0000, e}); endtask : check_bit
  task automatic check_page(input anr_pkg::anr_page_t a, input anr_pkg::anr_page_t e); cmp(a, e); endtask : check_page
  task automatic check_tech(input anr_pkg::anr_tech_t a, input anr_pkg::anr_tech_t e);
    cmp({13'h0000, a}, {13'h0000, e});
  endtask : check_tech

  // Page the block should send: a message page with no acknowledge bits.
  function automatic anr_pkg::anr_page_t mk(input logic m, input logic t, input logic [10:0] k);
    mk = {m, 1'b0, 1'b1, 1'b0, t, k};
  endfunction : mk

  // Page the partner sends: acknowledged message page.
  function automatic logic [15:0] pw(input logic m, input logic t, input logic [10:0] k);
    pw = {m, 1'b1, 1'b1, 1'b0, t, k};
  endfunction : pw

  // Expected technology from the common ability bits, best first.
  function automatic anr_pkg::anr_tech_t best(input logic [4:0] b);
    if (b[3]) return anr_pkg::TECH_TXFD;
    if (b[4]) return anr_pkg::TECH_T4;
    if (b[2]) return anr_pkg::TECH_TX;
    if (b[1]) return anr_pkg::TECH_10FD;
    if (b[0]) return anr_pkg::TECH_10;
    return anr_pkg::TECH_NONE;
  endfunction : best

  // Bounded waits; running out of time counts a mismatch and closes the run.
  task automatic wait_page(input anr_pkg::anr_page_t e);
    int n;
    n = 0;
    while (tx_page !== e && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    check_page(tx_page, e);
    if (n == 60) finish_test();
  endtask : wait_page
  task automatic wait_flag(input int k);
    int n;
    n = 0;
    while (flags[k] !== 1'b1 && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    check_bit(flags[k], 1'b1);
    if (n == 60) finish_test();
  endtask : wait_flag

  // Resets the block with a fresh local configuration.
  task automatic do_reset(input logic [4:0] a, input logic np, input logic avail);
    @(negedge i_clock);
    i_rstn = 1'b0;
    ability = a;
    local_np = np;
    np_avail = avail;
    repeat (4) @(negedge i_clock);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_clock);
  endtask : do_reset

  // Base word exchange with partner abilities p, then the acknowledge pulse.
  task automatic base_exchange(input logic np);
    u_partner.send_word({np, 1'b1, 4'h0, p, 5'h01}, 3);
    ack_complete = 1'b1;
    @(negedge i_clock);
    ack_complete = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask : base_exchange

  // Main sequence.
  initial begin
    {i_rstn, pd_tx, pd_t4, local_np, base_toggle, ack_complete, link_fail, renegotiate} = 8'h00;
    {np_avail, np_more, np_mp, np_code, ability, failures, comparisons} = '0;
    do_reset(5'h1F, 1'b0, 1'b0);
    // Parallel detect of fixed partners, supported and not.
    for (int k = 0; k < 4; k++) begin
      do_reset(k < 2 ? (k[0] ? 5'h04 : 5'h13) : (k[0] ? 5'h10 : 5'h0F), 1'b0, 1'b0);
      {pd_tx, pd_t4} = k < 2 ? 2'h2 : 2'h1;
      repeat (3) @(negedge i_clock);
      check_bit(link_up, k[0]);
      check_bit(refused, ~k[0]);
      check_bit(pma_tx_en, k[0] && k < 2);
      check_bit(pma_t4_en, k[0] && k >= 2);
      {pd_tx, pd_t4, renegotiate} = 3'h1;
      @(negedge i_clock);
      renegotiate = 1'b0;
      repeat (2) @(negedge i_clock);
      check_bit(refused, 1'b0);
    end
    $display("test parallel detect done");
    // Priority resolution over partner abilities, with restart on failure.
    for (int i = 0; i < 43; i++) begin
      p = (i < 32) ? i[4:0] : 5'(3 * (i - 32));
      do_reset((i < 32) ? 5'h1F : 5'h15, 1'b0, 1'b0);
      c = p & ability;
      eh = best(c);
      base_exchange(1'b0);
      check_tech(highest_common_technology, eh);
      check_bit(link_up, c != 5'h00);
      check_bit(refused, c == 5'h00);
      check_bit(full_duplex, eh == anr_pkg::TECH_TXFD || eh == anr_pkg::TECH_10FD);
      if (c != 5'h00) begin
        link_fail = 1'b1;
        wait_flag(2);
        check_bit(link_up, 1'b0);
        link_fail = 1'b0;
      end
    end
    $display("test resolution done");
    // Next pages with one user page, a short match and a repeated toggle.
    {np_more, np_mp, np_code} = {1'b0, 1'b1, 11'h155};
    do_reset(5'h1F, 1'b1, 1'b1);
    p = 5'h1F;
    base_exchange(1'b1);
    check_bit(tx_valid, 1'b1);
    wait_page(mk(1'b0, 1'b1, 11'h155));
    check_bit(np_avail, 1'b0);
    u_partner.send_word(pw(1'b1, 1'b1, 11'h0AA), 2);
    repeat (10) @(negedge i_clock);
    check_page(tx_page, mk(1'b0, 1'b1, 11'h155));
    u_partner.send_word(pw(1'b1, 1'b1, 11'h0AA), 1);
    wait_page(mk(1'b0, 1'b0, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b1, 1'b1, 11'h0AA), 3);
    repeat (10) @(negedge i_clock);
    check_page(tx_page, mk(1'b0, 1'b0, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b1, 1'b0, 11'h0BB), 3);
    wait_page(mk(1'b0, 1'b1, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b0, 1'b1, `ANR_NULL_CODE), 3);
    wait_flag(0);
    check_bit(tx_valid, 1'b0);
    $display("test next pages done");
    // Null pages only, then the final null with the more flag clear.
    do_reset(5'h1F, 1'b1, 1'b0);
    base_exchange(1'b1);
    wait_page(mk(1'b1, 1'b1, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b0, 1'b1, `ANR_NULL_CODE), 3);
    wait_page(mk(1'b0, 1'b0, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b0, 1'b0, `ANR_NULL_CODE), 3);
    wait_flag(0);
    $display("test null pages done");
    // An inconsistent page after a match stops next page transmission.
    do_reset(5'h1F, 1'b1, 1'b0);
    base_exchange(1'b1);
    u_partner.send_word(pw(1'b1, 1'b1, 11'h0AA), 3);
    wait_page(mk(1'b1, 1'b0, `ANR_NULL_CODE));
    u_partner.send_word(pw(1'b1, 1'b1, 11'h0AB), 3);
    wait_flag(1);
    check_bit(link_up, 1'b0);
    $display("test inconsistency done");
    finish_test();
  end
endmodule : anr_top_tb
